// ---- hw/bulk_seq_regs.svh ----
// Constants for the bulk transaction sequencer.
// Assumes inclusion by bare name from the hw folder.
`ifndef BULK_SEQ_REGS_SVH
`define BULK_SEQ_REGS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_IN_STAT 4'h1
`define REG_OUT_STAT 4'h2
`define REG_COUNTS 4'h3
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_INIT_BIT 0
`define CTRL_HALT_BIT 1
`define CTRL_ACCEPT_BIT 2
`define SEQ_RESET 5'h00
`define SEQ_ONE 5'h01
`define CNT_ONE 5'h01
`define CNT_ZERO 5'h00
`endif

// ---- hw/bulk_seq_pkg.sv ----
// Types for the bulk transaction sequencer.
// Assumes the constants header is included alongside.
package bulk_seq_pkg;
  typedef logic [4:0] seq_t;
  typedef enum logic [3:0] {
    TP_NONE = 4'h1,
    TP_ACK = 4'h2,
    TP_NRDY = 4'h4,
    TP_STALL = 4'h8
  } tp_kind_t;
  typedef enum logic [2:0] {
    IN_IDLE = 3'h1,
    IN_BURST = 3'h2,
    IN_WAIT = 3'h4
  } in_state_t;
endpackage : bulk_seq_pkg

// ---- hw/seq_counter.sv ----
// Five-bit wrapping sequence counter with load.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
`include "bulk_seq_regs.svh"
module seq_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [4:0] load_val_i,
  input wire logic incr_i,
  // Value
  output logic [4:0] seq_o
);
  typedef struct packed {
    logic [4:0] seq;
  } cnt_state_t;
  cnt_state_t st_r;
  cnt_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (clear_i) begin
      st_nxt.seq = `SEQ_RESET;
    end else if (load_i) begin
      st_nxt.seq = load_val_i;
    end else if (incr_i) begin
      st_nxt.seq = st_r.seq + `SEQ_ONE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{seq: `SEQ_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign seq_o = st_r.seq;
endmodule : seq_counter

// ---- hw/bulk_transaction_sequencer.sv ----
// Bulk IN and OUT sequence numbering, burst and retry handling.
// Assumes packet framing and CRC checks happen upstream, one event per cycle.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "bulk_seq_regs.svh"
module bulk_transaction_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Host ACK for the IN pipe
  input wire logic in_ack_i,
  input wire bulk_seq_pkg::seq_t in_ack_seq_i,
  input wire logic [4:0] in_ack_count_i,
  input wire logic in_ack_retry_i,
  // IN data source
  input wire logic src_avail_i,
  input wire logic src_short_i,
  input wire logic src_last_i,
  output logic src_take_o,
  // IN packet header out
  output logic dp_valid_o,
  output bulk_seq_pkg::seq_t dp_seq_o,
  output logic dp_eob_o,
  output logic dp_short_o,
  output logic in_done_o,
  // OUT packet in
  input wire logic out_dp_i,
  input wire logic out_hdr_ok_i,
  input wire bulk_seq_pkg::seq_t out_seq_i,
  input wire logic out_deferred_i,
  input wire logic out_payload_err_i,
  input wire logic out_last_i,
  input wire logic [4:0] out_buf_count_i,
  output logic out_accept_o,
  // Answer packet out
  output bulk_seq_pkg::tp_kind_t tp_kind_o,
  output bulk_seq_pkg::seq_t tp_seq_o,
  output logic [4:0] tp_count_o,
  output logic tp_retry_o
);
  import bulk_seq_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    in_state_t in_st;
    logic [4:0] credit;
    logic halt;
    logic accept_en;
    tp_kind_t tp_kind;
    seq_t tp_seq;
    logic [4:0] tp_count;
    logic tp_retry;
    logic dp_valid;
    seq_t dp_seq;
    logic dp_eob;
    logic dp_short;
    logic in_done;
    logic out_accept;
    logic [31:0] rdata;
  } seq_state_t;

  seq_state_t st_r;
  seq_state_t st_nxt;
  seq_t in_seq;
  seq_t out_seq;
  logic ep_init;
  logic in_load;
  logic in_incr;
  logic out_incr;
  logic send;
  logic ctrl_wr;
  logic credit_last;
  logic out_hdr_valid;
  logic out_can_take;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Five-bit addition wraps from 31 back to zero by itself.
  function automatic seq_t seq_plus_one(input seq_t s);
    seq_plus_one = s + `SEQ_ONE;
  endfunction : seq_plus_one

  // Builds the read word; unmapped offsets read as zero.
  function automatic logic [31:0] reg_read_word(input logic [3:0] a, input seq_state_t s,
    input seq_t iseq, input seq_t oseq);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `REG_CTRL: begin
        w = {29'h0, s.accept_en, s.halt, 1'b0};
      end
      `REG_IN_STAT: begin
        w = {24'h0, s.in_st, iseq};
      end
      `REG_OUT_STAT: begin
        w = {27'h0, oseq};
      end
      `REG_COUNTS: begin
        w = {27'h0, s.credit};
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    reg_read_word = w;
  endfunction : reg_read_word

  // ****************************************************************
  // Decodes
  // ****************************************************************
  assign ctrl_wr = reg_wr_i && (reg_addr_i == `REG_CTRL);
  // Endpoint initialisation clears both counters and the credit in one write.
  assign ep_init = ctrl_wr && reg_wdata_i[`CTRL_INIT_BIT];
  assign credit_last = (st_r.credit == `CNT_ONE);
  // A header passes only when its fields and its sequence number both match.
  assign out_hdr_valid = out_hdr_ok_i && (out_seq_i == out_seq);
  // Buffers count as free only while software has enabled the pipe.
  assign out_can_take = st_r.accept_en && (out_buf_count_i != `CNT_ZERO);

  // ****************************************************************
  // Sequence counters
  // ****************************************************************
  seq_counter u_in_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(ep_init),
    .load_i(in_load),
    .load_val_i(in_ack_seq_i),
    .incr_i(in_incr),
    .seq_o(in_seq)
  );

  seq_counter u_out_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(ep_init),
    .load_i(1'b0),
    .load_val_i(`SEQ_RESET),
    .incr_i(out_incr),
    .seq_o(out_seq)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    in_load = 1'b0;
    in_incr = 1'b0;
    out_incr = 1'b0;
    send = 1'b0;
    st_nxt.dp_valid = 1'b0;
    st_nxt.in_done = 1'b0;
    st_nxt.out_accept = 1'b0;
    st_nxt.tp_kind = TP_NONE;
    st_nxt.rdata = 32'h0000_0000;

    if (ctrl_wr) begin
      st_nxt.halt = reg_wdata_i[`CTRL_HALT_BIT];
      st_nxt.accept_en = reg_wdata_i[`CTRL_ACCEPT_BIT];
    end
    if (ep_init) begin
      st_nxt.in_st = IN_IDLE;
      st_nxt.credit = `CNT_ZERO;
    end else begin
      // IN pipe: a host ACK resets credit and may rewind.
      // The ACK wins over a send in the same cycle, so a rewound sequence is
      // never skipped by a packet already on its way.
      if (in_ack_i) begin
        st_nxt.credit = in_ack_count_i;
        if (in_ack_retry_i) begin
          in_load = 1'b1;
        end
        st_nxt.in_st = (in_ack_count_i != `CNT_ZERO) ? IN_BURST : IN_IDLE;
      end else begin
        case (st_r.in_st)
          IN_IDLE: begin
            // Waiting for the host to open a transfer with an ACK.
            st_nxt.in_st = IN_IDLE;
          end
          IN_BURST: begin
            // Packets keep flowing while credit remains.
            if (src_avail_i && !st_r.halt && (st_r.credit != `CNT_ZERO)) begin
              send = 1'b1;
              in_incr = 1'b1;
              st_nxt.dp_valid = 1'b1;
              st_nxt.dp_seq = in_seq;
              st_nxt.dp_short = src_short_i;
              // End of burst when data runs out before credit does.
              st_nxt.dp_eob = src_last_i && !src_short_i && !credit_last;
              st_nxt.credit = st_r.credit - `CNT_ONE;
              if (src_short_i || credit_last || src_last_i) begin
                st_nxt.in_done = src_short_i || credit_last;
                st_nxt.in_st = IN_WAIT;
              end
            end
          end
          IN_WAIT: begin
            // Transfer over; only a fresh ACK restarts the pipe.
            st_nxt.in_st = IN_WAIT;
          end
          default: begin
            st_nxt.in_st = IN_IDLE;
          end
        endcase
      end

      // OUT pipe: one answer per received packet whose header passes and is not deferred.
      if (out_dp_i) begin
        if (!out_hdr_valid) begin
          st_nxt.tp_kind = TP_NONE;
        end else if (out_deferred_i) begin
          st_nxt.tp_kind = TP_NONE;
        end else if (st_r.halt) begin
          // A halted endpoint answers STALL whatever the buffers hold.
          st_nxt.tp_kind = TP_STALL;
        end else if (!out_can_take) begin
          // No free buffer: the packet is dropped and the host must wait.
          st_nxt.tp_kind = TP_NRDY;
        end else if (out_payload_err_i) begin
          // The errored packet is dropped and the same sequence is asked for again.
          st_nxt.tp_kind = TP_ACK;
          st_nxt.tp_seq = out_seq;
          st_nxt.tp_retry = 1'b1;
          st_nxt.tp_count = out_buf_count_i;
        end else begin
          // Good packet: count it and ask for the next sequence number.
          out_incr = 1'b1;
          st_nxt.out_accept = 1'b1;
          st_nxt.tp_kind = TP_ACK;
          st_nxt.tp_seq = seq_plus_one(out_seq);
          st_nxt.tp_retry = 1'b0;
          st_nxt.tp_count = out_buf_count_i;
        end
      end
    end

    if (reg_rd_i) begin
      st_nxt.rdata = reg_read_word(reg_addr_i, st_r, in_seq, out_seq);
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset leaves the answer channel showing no packet rather than all zeros.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{in_st: IN_IDLE, tp_kind: TP_NONE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign src_take_o = send;
  assign dp_valid_o = st_r.dp_valid;
  assign dp_seq_o = st_r.dp_seq;
  assign dp_eob_o = st_r.dp_eob;
  assign dp_short_o = st_r.dp_short;
  assign in_done_o = st_r.in_done;
  assign out_accept_o = st_r.out_accept;
  assign tp_kind_o = st_r.tp_kind;
  assign tp_seq_o = st_r.tp_seq;
  assign tp_count_o = st_r.tp_count;
  assign tp_retry_o = st_r.tp_retry;
  assign reg_rdata_o = st_r.rdata;
endmodule : bulk_transaction_sequencer

// ---- tb/bulk_seq_sva.sv ----
// Port checker for the bulk transaction sequencer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bulk_seq_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // IN side
  input wire logic in_ack_i,
  input wire bulk_seq_pkg::seq_t in_ack_seq_i,
  input wire logic in_ack_retry_i,
  input wire logic src_take_o,
  input wire logic dp_valid_o,
  input wire bulk_seq_pkg::seq_t dp_seq_o,
  input wire logic dp_eob_o,
  input wire logic dp_short_o,
  input wire logic in_done_o,
  // OUT side
  input wire logic out_dp_i,
  input wire logic out_hdr_ok_i,
  input wire bulk_seq_pkg::seq_t out_seq_i,
  input wire logic out_deferred_i,
  input wire logic out_payload_err_i,
  input wire logic [4:0] out_buf_count_i,
  input wire logic out_accept_o,
  input wire bulk_seq_pkg::tp_kind_t tp_kind_o,
  input wire bulk_seq_pkg::seq_t tp_seq_o,
  input wire logic [4:0] tp_count_o,
  input wire logic tp_retry_o
);
  import bulk_seq_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_take_then_send: assert property (src_take_o |=> dp_valid_o)
    else $error("taken packet not sent");
  a_seq_step: assert property (dp_valid_o && $past(dp_valid_o) |->
    dp_seq_o == $past(dp_seq_o) + 5'h01) else $error("sequence not stepped");
  a_retry_rewind: assert property (in_ack_i && in_ack_retry_i ##1 src_take_o |=>
    dp_seq_o == $past(in_ack_seq_i, 2)) else $error("retry sequence not used");
  a_short_no_eob: assert property (dp_valid_o && dp_short_o |-> !dp_eob_o)
    else $error("short packet marked end");
  a_done_with_dp: assert property (in_done_o |-> dp_valid_o)
    else $error("done without packet");
  a_bad_hdr_quiet: assert property (out_dp_i && !out_hdr_ok_i |=> tp_kind_o == TP_NONE)
    else $error("answer to bad header");
  a_stall_cause: assert property (tp_kind_o == TP_STALL |->
    $past(out_dp_i && out_hdr_ok_i && !out_deferred_i)) else $error("stray stall");
  a_err_retry: assert property (out_dp_i && out_hdr_ok_i && !out_deferred_i &&
    out_payload_err_i |=> !out_accept_o && (tp_kind_o != TP_ACK || tp_retry_o))
    else $error("errored packet accepted");
  a_accept_ack: assert property (out_accept_o |-> tp_kind_o == TP_ACK && !tp_retry_o &&
    tp_seq_o == $past(out_seq_i) + 5'h01 && tp_count_o == $past(out_buf_count_i))
    else $error("accept answer wrong");
endmodule : bulk_seq_sva
bind bulk_transaction_sequencer bulk_seq_sva chk_u (.*);

// ---- tb/host_model.sv ----
// Host model: sends IN acknowledgements and OUT data packets.
// Assumes tasks are called from the bench between clock edges.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk_i,
  // IN acknowledgement
  output logic ack_o,
  output bulk_seq_pkg::seq_t ack_seq_o,
  output logic [4:0] ack_cnt_o,
  output logic ack_rty_o,
  // OUT packet header
  output logic dp_o,
  output logic ok_o,
  output bulk_seq_pkg::seq_t seq_o,
  output logic def_o,
  output logic err_o
);
  import bulk_seq_pkg::*;
  initial begin
    {ack_o, ack_seq_o, ack_cnt_o, ack_rty_o, dp_o, ok_o, seq_o, def_o, err_o} = '0;
  end
  // Released sequence and count fields show the inverse so stale values never look valid.
  task automatic ack(input seq_t s, input logic [4:0] n, input logic r);
    @(posedge clk_i);
    ack_o <= 1'b1;
    ack_seq_o <= s;
    ack_cnt_o <= n;
    ack_rty_o <= r;
    @(posedge clk_i);
    ack_o <= 1'b0;
    ack_seq_o <= ~s;
    ack_cnt_o <= ~n;
  endtask : ack
  task automatic dp(input seq_t s, input logic [2:0] f);
    @(posedge clk_i);
    dp_o <= 1'b1;
    seq_o <= s;
    {ok_o, def_o, err_o} <= f;
    @(posedge clk_i);
    dp_o <= 1'b0;
    seq_o <= ~s;
  endtask : dp
endmodule : host_model

// ---- tb/test_bulk_transaction_sequencer.sv ----
// Self-checking bench for the bulk transaction sequencer.
// Assumes the checker is bound and the host model drives the far side.
`timescale 1ns/1ps
`include "bulk_seq_regs.svh"
module test_bulk_transaction_sequencer;
  import bulk_seq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, src_avail_i = 1'b1, src_short_i = 1'b0;
  logic src_last_i = 1'b0, out_last_i = 1'b0;
  logic [4:0] out_buf_count_i = 5'h04;
  logic in_ack_i, in_ack_retry_i, out_dp_i, out_hdr_ok_i, out_deferred_i, out_payload_err_i;
  seq_t in_ack_seq_i, out_seq_i, dp_seq_o, tp_seq_o;
  logic [4:0] in_ack_count_i, tp_count_o;
  logic [31:0] reg_rdata_o;
  logic src_take_o, dp_valid_o, dp_eob_o, dp_short_o, in_done_o, out_accept_o, tp_retry_o;
  tp_kind_t tp_kind_o;
  logic [7:0] got[$];
  int mismatches = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  bulk_transaction_sequencer dut_u (.*);
  host_model host_u (.clk_i(clk_i), .ack_o(in_ack_i), .ack_seq_o(in_ack_seq_i),
    .ack_cnt_o(in_ack_count_i), .ack_rty_o(in_ack_retry_i), .dp_o(out_dp_i),
    .ok_o(out_hdr_ok_i), .seq_o(out_seq_i), .def_o(out_deferred_i), .err_o(out_payload_err_i));
  always @(posedge clk_i) if (dp_valid_o) got.push_back({in_done_o, dp_short_o, dp_eob_o, dp_seq_o});
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata_o[15:0]);
  endtask : rd
  // One acknowledgement, then the packets sent behind it; e holds up to two headers.
  task automatic in_case(input seq_t s, input logic [4:0] n, input logic r, input logic [1:0] ls,
    input int k, input logic [15:0] e);
    {src_last_i, src_short_i} <= ls;
    got.delete();
    host_u.ack(s, n, r);
    repeat (6) @(posedge clk_i);
    chk("dp_count", 16'(k), 16'(got.size()));
    for (int i = 0; i < got.size() && i < 2; i++) chk("dp_header", e[8*i+:8], got[i]);
  endtask : in_case
  task automatic out_case(input seq_t s, input logic [2:0] f, input logic [15:0] e);
    host_u.dp(s, f);
    #1 chk("out_answer", e, {out_accept_o, tp_kind_o,
      tp_kind_o == TP_ACK ? {tp_retry_o, tp_seq_o, tp_count_o} : 11'h0});
  endtask : out_case
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(`REG_CTRL, 32'h1);
    out_case(5'h00, 3'b100, {1'b0, TP_NRDY, 11'h0});
    wr(`REG_CTRL, 32'h4);
    in_case(5'h00, 5'h02, 1'b0, 2'b00, 2, 16'h8100);
    in_case(5'h02, 5'h03, 1'b0, 2'b10, 1, 16'h0022);
    rd(`REG_COUNTS, 16'h0002);
    in_case(5'h03, 5'h03, 1'b0, 2'b01, 1, 16'h00c3);
    in_case(5'h1f, 5'h02, 1'b1, 2'b00, 2, 16'h801f);
    in_case(5'h01, 5'h00, 1'b0, 2'b00, 0, 16'h0000);
    rd(`REG_IN_STAT, 16'h0021);
    rd(4'h9, 16'h0000);
    out_case(5'h00, 3'b100, {1'b1, TP_ACK, 1'b0, 5'h01, 5'h04});
    out_case(5'h01, 3'b101, {1'b0, TP_ACK, 1'b1, 5'h01, 5'h04});
    out_case(5'h01, 3'b000, {1'b0, TP_NONE, 11'h0});
    out_case(5'h05, 3'b100, {1'b0, TP_NONE, 11'h0});
    out_case(5'h01, 3'b110, {1'b0, TP_NONE, 11'h0});
    rd(`REG_OUT_STAT, 16'h0001);
    wr(`REG_CTRL, 32'h6);
    out_case(5'h01, 3'b100, {1'b0, TP_STALL, 11'h0});
    rd(`REG_CTRL, 16'h0006);
    in_case(5'h01, 5'h02, 1'b0, 2'b00, 0, 16'h0000);
    report_and_stop();
  end
endmodule : test_bulk_transaction_sequencer
